//--- core/usync_pkg.sv
// Purpose: Shared constants, types and helpers for the synchronous serial port.
// Assumes: 8-bit register port; core clock of 100 MHz.
// Notes: Both ends of the link import this package.
package usync_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0C;
   localparam logic [7:0] ADDR_RX_CTRL = 8'h18;
   localparam logic [7:0] ADDR_TX_BUF = 8'h19;
   localparam logic [7:0] ADDR_RX_BUF = 8'h1A;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h8C;
   localparam logic [7:0] ADDR_TX_CTRL = 8'h98;
   localparam logic [7:0] ADDR_BAUD = 8'h99;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int FLAG_RX_DONE = 5;
   localparam int FLAG_TX_EMPTY = 4;
   localparam int RX_PORT_EN = 7;
   localparam int RX_NINE = 6;
   localparam int RX_SINGLE = 5;
   localparam int RX_CONT = 4;
   localparam int RX_OVERRUN = 1;
   localparam int RX_NINTH = 0;
   localparam int TX_CLK_SRC = 7;
   localparam int TX_NINE = 6;
   localparam int TX_EN = 5;
   localparam int TX_SYNC = 4;
   localparam int TX_SHIFT_EMPTY = 1;
   localparam int TX_NINTH = 0;
   // ****************************************
   // Write masks and reset values
   // ****************************************
   localparam logic [7:0] TX_CTRL_WMASK = 8'hF5;
   localparam logic [7:0] RX_CTRL_WMASK = 8'hF8;
   localparam logic [7:0] IRQ_EN_WMASK = 8'h30;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_TX_CTRL = 8'h02;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CORE_PERIOD_NS = 10;
   localparam int LINK_PERIOD_NS = 160;
   localparam int FAR_HALF_CYCLES = LINK_PERIOD_NS / (2 * CORE_PERIOD_NS);
   localparam logic [3:0] WORD_BITS_8 = 4'h8;
   localparam logic [3:0] WORD_BITS_9 = 4'h9;
   // Cycles a sender keeps the data line after its last bit; the receiver sees pin edges late.
   localparam logic [1:0] LINE_HOLD_CYCLES = 2'h3;

   typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_TX, ST_RX} usync_state_t;

   // Number of bits in a word for the selected width.
   function automatic logic [3:0] usync_word_bits(input logic nine);
      usync_word_bits = nine ? WORD_BITS_9 : WORD_BITS_8;
   endfunction
endpackage

//--- core/usync_link_if.sv
// Purpose: Clock and data lines between the port and the far node.
// Assumes: Enables are active low; undriven clock idles low, data idles high.
// Notes: The line levels are resolved here from the enables.
`timescale 1ns/1ps
interface usync_link_if;
   logic dev_ck_out;
   logic dev_ck_oe_n;
   logic dev_dt_out;
   logic dev_dt_oe_n;
   logic far_ck_out;
   logic far_ck_oe_n;
   logic far_dt_out;
   logic far_dt_oe_n;
   logic ck_line;
   logic dt_line;

   assign ck_line = !dev_ck_oe_n ? dev_ck_out : (!far_ck_oe_n ? far_ck_out : 1'b0);
   assign dt_line = !dev_dt_oe_n ? dev_dt_out : (!far_dt_oe_n ? far_dt_out : 1'b1);

   modport dev (output dev_ck_out, output dev_ck_oe_n, output dev_dt_out,
                output dev_dt_oe_n, input ck_line, input dt_line);
   modport far (output far_ck_out, output far_ck_oe_n, output far_dt_out,
                output far_dt_oe_n, input ck_line, input dt_line);
endinterface

//--- core/usync_dev.sv
// Purpose: Synchronous half-duplex serial port, device end, with register port.
// Assumes: Far node changes data on rising clock edges and samples on falling ones.
// Notes: One shifter serves both directions, so the port is half duplex.
`timescale 1ns/1ps
module usync_dev (
   input wire logic core_clk,
   input wire logic arst_n,
   usync_link_if.dev link,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic sleep_req,
   output logic [7:0] reg_rdata_q,
   output logic wake_irq_q
);
   import usync_pkg::*;

   logic [7:0] tx_ctrl_q, rx_ctrl_q, irq_en_q, baud_q, tx_buf_q, rx_buf_q;
   logic buf_full_q, shifter_empty_q, rx_done_q, overrun_q, rx_ninth_q;
   logic [8:0] shifter_q, half_cnt_q, rx_word;
   logic [3:0] bit_cnt_q, nbits;
   logic [1:0] tail_q;
   logic ck_int_q, ck_s1_q, ck_s2_q, ck_s3_q, dt_s1_q, dt_s2_q;
   logic [7:0] rd_mux;
   usync_state_t state_q;
   logic sync_on, master, tx_en, rx_en, tx_empty_flag, wr_txbuf, rd_rxbuf;
   logic busy, run_clk, rise, fall, last_bit, tx_done, tx_abort, rx_word_done;

   // ****************************************
   // Decode
   // ****************************************
   assign sync_on = rx_ctrl_q[RX_PORT_EN] & tx_ctrl_q[TX_SYNC];
   assign master = tx_ctrl_q[TX_CLK_SRC];
   assign tx_en = tx_ctrl_q[TX_EN];
   // Continuous wins over single; single is ignored in slave mode.
   // An overrun halts reception until continuous is cleared.
   assign rx_en = (rx_ctrl_q[RX_CONT] | (master & rx_ctrl_q[RX_SINGLE])) & ~overrun_q;
   // Enabling transmit with an empty buffer raises the flag at once.
   assign tx_empty_flag = tx_en & ~buf_full_q;
   assign wr_txbuf = reg_wr && (reg_addr == ADDR_TX_BUF);
   assign rd_rxbuf = reg_rd && (reg_addr == ADDR_RX_BUF);
   assign busy = (state_q == ST_TX) || (state_q == ST_RX);
   assign nbits = usync_word_bits((state_q == ST_TX) ? tx_ctrl_q[TX_NINE] : rx_ctrl_q[RX_NINE]);
   assign last_bit = (bit_cnt_q == nbits - 4'h1);

   // ****************************************
   // Shift clock
   // ****************************************
   // The master clock freezes in sleep; a slave follows the pin, so sleep
   // does not stop it.
   assign run_clk = master & busy & ~sleep_req;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         half_cnt_q <= 9'h000;
         ck_int_q <= 1'b0;
      end else if (!(master && busy)) begin
         half_cnt_q <= 9'h000;
         ck_int_q <= 1'b0;
      end else if (run_clk) begin
         if (half_cnt_q == {baud_q, 1'b1}) begin
            half_cnt_q <= 9'h000;
            ck_int_q <= ~ck_int_q;
         end else begin
            half_cnt_q <= half_cnt_q + 9'h001;
         end
      end
   end

   // Third stage only feeds edge detection; the first stage feeds nothing else.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ck_s1_q <= 1'b0;
         ck_s2_q <= 1'b0;
         ck_s3_q <= 1'b0;
         dt_s1_q <= 1'b1;
         dt_s2_q <= 1'b1;
      end else begin
         ck_s1_q <= link.ck_line;
         ck_s2_q <= ck_s1_q;
         ck_s3_q <= ck_s2_q;
         dt_s1_q <= link.dt_line;
         dt_s2_q <= dt_s1_q;
      end
   end

   assign rise = master ? (run_clk && half_cnt_q == {baud_q, 1'b1} && !ck_int_q)
                        : (ck_s2_q && !ck_s3_q);
   assign fall = master ? (run_clk && half_cnt_q == {baud_q, 1'b1} && ck_int_q)
                        : (!ck_s2_q && ck_s3_q);

   // ****************************************
   // Word engine
   // ****************************************
   assign tx_done = (state_q == ST_TX) && fall && last_bit;
   assign tx_abort = (state_q == ST_TX) && !(tx_en && sync_on);
   assign rx_word_done = (state_q == ST_RX) && sync_on && rx_en && fall && last_bit;

   always_comb begin
      rx_word = shifter_q;
      rx_word[bit_cnt_q] = dt_s2_q;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         shifter_q <= 9'h000;
         tail_q <= 2'h0;
      end else begin
         // The far end samples a late copy of the line, so the last bit is held.
         if (tx_done) begin
            tail_q <= LINE_HOLD_CYCLES;
         end else if (tail_q != 2'h0) begin
            tail_q <= tail_q - 2'h1;
         end
         case (state_q)
            ST_IDLE: begin
               bit_cnt_q <= 4'h0;
               // Transmit starts only while rx_en is clear, so single does not block it in slave mode.
               if (sync_on && tx_en && buf_full_q && !rx_en && !wr_txbuf && tail_q == 2'h0) begin
                  state_q <= ST_LOAD;
               end else if (sync_on && rx_en) begin
                  state_q <= ST_RX;
               end
            end
            ST_LOAD: begin
               shifter_q <= {tx_ctrl_q[TX_NINTH], tx_buf_q};
               state_q <= ST_TX;
            end
            ST_TX: begin
               if (tx_abort) begin
                  state_q <= ST_IDLE;
               end else if (fall) begin
                  if (last_bit) begin
                     state_q <= ST_IDLE;
                  end else begin
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end
               end
            end
            ST_RX: begin
               if (!(sync_on && rx_en)) begin
                  state_q <= ST_IDLE;
               end else if (fall) begin
                  shifter_q <= rx_word;
                  if (last_bit) begin
                     state_q <= ST_IDLE;
                  end else begin
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // The shifter itself is never readable or writable.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         shifter_empty_q <= RST_TX_CTRL[TX_SHIFT_EMPTY];
      end else if (state_q == ST_LOAD) begin
         shifter_empty_q <= 1'b0;
      end else if (tx_done || tx_abort) begin
         shifter_empty_q <= 1'b1;
      end
   end

   // A write in the load cycle leaves the buffer full with the new word.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         buf_full_q <= 1'b0;
         tx_buf_q <= RST_ZERO;
      end else begin
         if (wr_txbuf) begin
            buf_full_q <= 1'b1;
            tx_buf_q <= reg_wdata;
         end else if (state_q == ST_LOAD) begin
            buf_full_q <= 1'b0;
         end
      end
   end

   // A new word beats a read of the buffer in the same cycle.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_done_q <= 1'b0;
         overrun_q <= 1'b0;
         rx_buf_q <= RST_ZERO;
         rx_ninth_q <= 1'b0;
      end else begin
         if (!rx_ctrl_q[RX_CONT]) begin
            overrun_q <= 1'b0;
         end
         if (rx_word_done && rx_done_q && !rd_rxbuf) begin
            overrun_q <= 1'b1;
         end else if (rx_word_done) begin
            rx_buf_q <= rx_word[7:0];
            rx_ninth_q <= rx_ctrl_q[RX_NINE] & rx_word[8];
            rx_done_q <= 1'b1;
         end else if (rd_rxbuf) begin
            rx_done_q <= 1'b0;
         end
      end
   end

   // ****************************************
   // Register port
   // ****************************************
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_ctrl_q <= RST_TX_CTRL & TX_CTRL_WMASK;
         rx_ctrl_q <= RST_ZERO;
         irq_en_q <= RST_ZERO;
         baud_q <= RST_ZERO;
      end else begin
         // Single receive drops itself after one word in master mode.
         if (rx_word_done && master && !rx_ctrl_q[RX_CONT]) begin
            rx_ctrl_q[RX_SINGLE] <= 1'b0;
         end
         if (reg_wr) begin
            case (reg_addr)
               ADDR_TX_CTRL: tx_ctrl_q <= (tx_ctrl_q & ~TX_CTRL_WMASK) | (reg_wdata & TX_CTRL_WMASK);
               ADDR_RX_CTRL: rx_ctrl_q <= (rx_ctrl_q & ~RX_CTRL_WMASK) | (reg_wdata & RX_CTRL_WMASK);
               ADDR_IRQ_EN: irq_en_q <= reg_wdata & IRQ_EN_WMASK;
               ADDR_BAUD: baud_q <= reg_wdata;
               default: ;
            endcase
         end
      end
   end

   always_comb begin
      rd_mux = 8'h00;
      case (reg_addr)
         ADDR_IRQ_FLAGS: begin
            rd_mux[FLAG_RX_DONE] = rx_done_q;
            rd_mux[FLAG_TX_EMPTY] = tx_empty_flag;
         end
         ADDR_RX_CTRL: begin
            rd_mux = rx_ctrl_q & RX_CTRL_WMASK;
            rd_mux[RX_OVERRUN] = overrun_q;
            rd_mux[RX_NINTH] = rx_ninth_q;
         end
         ADDR_TX_BUF: rd_mux = tx_buf_q;
         ADDR_RX_BUF: rd_mux = rx_buf_q;
         ADDR_IRQ_EN: rd_mux = irq_en_q;
         ADDR_TX_CTRL: begin
            rd_mux = tx_ctrl_q & TX_CTRL_WMASK;
            rd_mux[TX_SHIFT_EMPTY] = shifter_empty_q;
         end
         ADDR_BAUD: rd_mux = baud_q;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata_q <= 8'h00;
      end else begin
         reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // Shifter-empty has no path here; only the two flags do.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_irq_q <= 1'b0;
      end else begin
         wake_irq_q <= (tx_empty_flag & irq_en_q[FLAG_TX_EMPTY])
                     | (rx_done_q & irq_en_q[FLAG_RX_DONE]);
      end
   end

   // ****************************************
   // Pins
   // ****************************************
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         link.dev_ck_out <= 1'b0;
         link.dev_ck_oe_n <= 1'b1;
         link.dev_dt_out <= 1'b1;
         link.dev_dt_oe_n <= 1'b1;
      end else begin
         link.dev_ck_out <= master & ck_int_q;
         link.dev_ck_oe_n <= ~(sync_on & master);
         link.dev_dt_oe_n <= ~(sync_on && (state_q == ST_LOAD || state_q == ST_TX
                                           || tail_q == LINE_HOLD_CYCLES));
         if (state_q == ST_LOAD) begin
            link.dev_dt_out <= tx_buf_q[0];
         end else if (state_q == ST_TX && rise) begin
            link.dev_dt_out <= shifter_q[bit_cnt_q];
         end
      end
   end
endmodule

//--- core/usync_far.sv
// Purpose: Far node of the synchronous serial link.
// Assumes: Port changes data on rising edges and samples on falling edges.
// Notes: When it does not make the clock it follows the port's clock pin.
`timescale 1ns/1ps
module usync_far #(
   parameter int HALF_CYCLES = usync_pkg::FAR_HALF_CYCLES
) (
   input wire logic core_clk,
   input wire logic arst_n,
   usync_link_if.far link,
   input wire logic clk_gen,
   input wire logic nine_bit,
   input wire logic tx_valid,
   input wire logic [8:0] tx_data,
   input wire logic rx_req,
   output logic tx_ready_q,
   output logic rx_valid_q,
   output logic [8:0] rx_data_q
);
   import usync_pkg::*;

   usync_state_t state_q;
   logic [8:0] tx_word_q, shift_q;
   logic [3:0] bit_cnt_q, nbits;
   logic [1:0] tail_q;
   logic [7:0] half_cnt_q;
   logic ck_int_q, ck_s1_q, ck_s2_q, ck_s3_q, dt_s1_q, dt_s2_q;
   logic busy, half_end, rise, fall, last_bit;

   assign nbits = usync_word_bits(nine_bit);
   assign last_bit = (bit_cnt_q == nbits - 4'h1);
   assign busy = (state_q == ST_TX) || (state_q == ST_RX);
   assign half_end = (half_cnt_q == 8'(HALF_CYCLES - 1));
   assign rise = clk_gen ? (busy && half_end && !ck_int_q) : (ck_s2_q && !ck_s3_q);
   assign fall = clk_gen ? (busy && half_end && ck_int_q) : (!ck_s2_q && ck_s3_q);

   // ****************************************
   // Clock and synchronisers
   // ****************************************
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         half_cnt_q <= 8'h00;
         ck_int_q <= 1'b0;
      end else if (!(clk_gen && busy)) begin
         half_cnt_q <= 8'h00;
         ck_int_q <= 1'b0;
      end else if (half_end) begin
         half_cnt_q <= 8'h00;
         ck_int_q <= ~ck_int_q;
      end else begin
         half_cnt_q <= half_cnt_q + 8'h01;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ck_s1_q <= 1'b0;
         ck_s2_q <= 1'b0;
         ck_s3_q <= 1'b0;
         dt_s1_q <= 1'b1;
         dt_s2_q <= 1'b1;
      end else begin
         ck_s1_q <= link.ck_line;
         ck_s2_q <= ck_s1_q;
         ck_s3_q <= ck_s2_q;
         dt_s1_q <= link.dt_line;
         dt_s2_q <= dt_s1_q;
      end
   end

   // ****************************************
   // Word engine
   // ****************************************
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q <= 9'h000;
         tx_word_q <= 9'h000;
         tx_ready_q <= 1'b1;
         rx_valid_q <= 1'b0;
         rx_data_q <= 9'h000;
         link.far_dt_out <= 1'b1;
         link.far_dt_oe_n <= 1'b1;
         tail_q <= 2'h0;
      end else begin
         rx_valid_q <= 1'b0;
         // The last bit stays on the line until the port has sampled it.
         if (tail_q != 2'h0) begin
            tail_q <= tail_q - 2'h1;
         end
         if (tail_q == LINE_HOLD_CYCLES - 2'h1) begin
            link.far_dt_oe_n <= 1'b1;
         end
         if (tx_valid && tx_ready_q) begin
            tx_word_q <= tx_data;
            tx_ready_q <= 1'b0;
         end
         case (state_q)
            ST_IDLE: begin
               bit_cnt_q <= 4'h0;
               if (tail_q == 2'h0 && clk_gen && !tx_ready_q) begin
                  state_q <= ST_TX;
                  link.far_dt_out <= tx_word_q[0];
                  link.far_dt_oe_n <= 1'b0;
               end else if (tail_q == 2'h0 && clk_gen && rx_req) begin
                  state_q <= ST_RX;
               end else if (tail_q == 2'h0 && !clk_gen && rise) begin
                  state_q <= tx_ready_q ? ST_RX : ST_TX;
                  link.far_dt_out <= tx_word_q[0];
                  link.far_dt_oe_n <= tx_ready_q;
               end
            end
            ST_TX: begin
               if (rise) begin
                  link.far_dt_out <= tx_word_q[bit_cnt_q];
               end
               if (fall) begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if (last_bit) begin
                     state_q <= ST_IDLE;
                     tx_ready_q <= 1'b1;
                     tail_q <= LINE_HOLD_CYCLES;
                  end
               end
            end
            ST_RX: begin
               if (fall) begin
                  shift_q[bit_cnt_q] <= dt_s2_q;
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if (last_bit) begin
                     state_q <= ST_IDLE;
                     rx_valid_q <= 1'b1;
                     rx_data_q <= nine_bit ? {dt_s2_q, shift_q[7:0]}
                                           : {1'b0, dt_s2_q, shift_q[6:0]};
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         link.far_ck_out <= 1'b0;
         link.far_ck_oe_n <= 1'b1;
      end else begin
         link.far_ck_out <= ck_int_q;
         link.far_ck_oe_n <= ~clk_gen;
      end
   end
endmodule

//--- dv/usync_monitor.sv
// Purpose: Wire checks on the link between the port and the far node.
// Assumes: Port divisor 3 and far half period of 8 core cycles.
// Notes: Sees only the interface signals.
`timescale 1ns/1ps
module usync_monitor (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic dev_ck_out,
   input wire logic dev_ck_oe_n,
   input wire logic dev_dt_out,
   input wire logic dev_dt_oe_n,
   input wire logic far_ck_out,
   input wire logic far_ck_oe_n,
   input wire logic far_dt_out,
   input wire logic far_dt_oe_n,
   input wire logic ck_line,
   input wire logic dt_line
);
   // ****************************************
   // Falling edges counted while the port sends
   // ****************************************
   logic [3:0] bits_q;
   logic ck_q;
   logic oe_q;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         bits_q <= 4'h0;
         ck_q <= 1'b0;
         oe_q <= 1'b1;
      end else begin
         ck_q <= ck_line;
         oe_q <= dev_dt_oe_n;
         if (oe_q && !dev_dt_oe_n) begin
            bits_q <= 4'h0;
         end else if (ck_q && !ck_line && !oe_q) begin
            bits_q <= bits_q + 4'h1;
         end
      end
   end
   default clocking mon_cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);
   // ****************************************
   // Assertions and covers
   // ****************************************
   a_ck_one_driver: assert property (!(!dev_ck_oe_n && !far_ck_oe_n))
      else $error("both ends drive the clock line");
   a_half_duplex: assert property (!(!dev_dt_oe_n && !far_dt_oe_n))
      else $error("both ends drive the data line");
   a_master_high_time: assert property ($rose(dev_ck_out) && !dev_ck_oe_n |=> dev_ck_out [*7])
      else $error("master clock high phase too short");
   a_master_low_time: assert property ($fell(dev_ck_out) && !dev_dt_oe_n |=> !dev_ck_out [*7])
      else $error("master clock low phase too short");
   a_word_starts_low: assert property ($fell(dev_dt_oe_n) |-> !ck_line)
      else $error("word started with the clock high");
   a_dev_data_holds: assert property ($fell(ck_line) && !dev_dt_oe_n |=>
      (dev_dt_oe_n || $stable(dev_dt_out)) [*2])
      else $error("port data changed after a falling edge");
   a_far_data_holds: assert property ($fell(ck_line) && !far_dt_oe_n |=>
      (far_dt_oe_n || $stable(far_dt_out)) [*2])
      else $error("far data changed after a falling edge");
   a_word_length: assert property ($rose(dev_dt_oe_n) |=> bits_q == 4'h8 || bits_q == 4'h9)
      else $error("port word length wrong");
   c_dev_word: cover property ($rose(dev_dt_oe_n));
   c_far_word: cover property ($rose(far_dt_oe_n));
   c_far_clock: cover property ($rose(far_ck_out));
endmodule

//--- dv/test_usart_synchronous_mode.sv
// Purpose: Self-checking bench for the port and far node joined by the link.
// Assumes: Divisor 3 and the far node's default half period.
// Notes: Registers are reached over the plain register port.
`timescale 1ns/1ps
module test_usart_synchronous_mode;
   import usync_pkg::*;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sleep_req = 1'b0;
   logic clk_gen = 1'b0;
   logic nine_bit = 1'b0;
   logic tx_valid = 1'b0;
   logic [8:0] tx_data = 9'h000;
   logic rx_req = 1'b0;
   logic [7:0] reg_rdata_q;
   logic wake_irq_q;
   logic tx_ready_q;
   logic rx_valid_q;
   logic [8:0] rx_data_q;
   logic [7:0] v;
   int num_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   usync_link_if link ();
   usync_dev usync_dev_i (.core_clk(core_clk), .arst_n(arst_n), .link(link),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .sleep_req(sleep_req), .reg_rdata_q(reg_rdata_q), .wake_irq_q(wake_irq_q));
   usync_far #(.HALF_CYCLES(FAR_HALF_CYCLES)) usync_far_i (.core_clk(core_clk),
      .arst_n(arst_n), .link(link), .clk_gen(clk_gen), .nine_bit(nine_bit),
      .tx_valid(tx_valid), .tx_data(tx_data), .rx_req(rx_req), .tx_ready_q(tx_ready_q),
      .rx_valid_q(rx_valid_q), .rx_data_q(rx_data_q));
   usync_monitor usync_monitor_i (.core_clk(core_clk), .arst_n(arst_n),
      .dev_ck_out(link.dev_ck_out), .dev_ck_oe_n(link.dev_ck_oe_n),
      .dev_dt_out(link.dev_dt_out), .dev_dt_oe_n(link.dev_dt_oe_n),
      .far_ck_out(link.far_ck_out), .far_ck_oe_n(link.far_ck_oe_n),
      .far_dt_out(link.far_dt_out), .far_dt_oe_n(link.far_dt_oe_n),
      .ck_line(link.ck_line), .dt_line(link.dt_line));
   always #5 core_clk = ~core_clk;
   // ****************************************
   // Access and check tasks
   // ****************************************
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         num_errors++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata_q;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      rd(a);
      chk({1'b0, v}, {1'b0, exp});
   endtask
   // Polling keeps the bus busy, but the bound stops a dead receiver hanging the run.
   task automatic poll();
      repeat (300) begin
         rd(ADDR_IRQ_FLAGS);
         if (v[FLAG_RX_DONE] === 1'b1) break;
      end
   endtask
   task automatic rxw(input logic [8:0] exp);
      repeat (400) begin
         @(posedge core_clk);
         #1;
         if (rx_valid_q === 1'b1) break;
      end
      chk(rx_data_q, exp);
   endtask
   task automatic offer(input logic [8:0] d);
      @(posedge core_clk);
      tx_data <= d;
      tx_valid <= 1'b1;
      repeat (400) begin
         @(posedge core_clk);
         if (tx_ready_q === 1'b1) break;
      end
      tx_valid <= 1'b0;
   endtask
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         final_report();
      end
   end
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      rdc(ADDR_TX_CTRL, RST_TX_CTRL);
      rdc(ADDR_IRQ_FLAGS, RST_ZERO);
      rdc(ADDR_RX_CTRL, RST_ZERO);
      rdc(8'h1B, RST_ZERO);
      $display("reset test done");
      wr(ADDR_BAUD, 8'h03);
      wr(ADDR_RX_CTRL, 8'h80);
      wr(ADDR_TX_CTRL, 8'hB0);
      rdc(ADDR_IRQ_FLAGS, 8'h10);
      wr(ADDR_IRQ_FLAGS, 8'h00);
      rdc(ADDR_IRQ_FLAGS, 8'h10);
      wr(ADDR_TX_BUF, 8'hA5);
      wr(ADDR_TX_BUF, 8'h3C);
      rdc(ADDR_IRQ_FLAGS, 8'h00);
      rdc(ADDR_TX_CTRL, 8'hB0);
      rxw(9'h0A5);
      rxw(9'h03C);
      rdc(ADDR_IRQ_FLAGS, 8'h10);
      rdc(ADDR_TX_CTRL, 8'hB2);
      wr(ADDR_IRQ_EN, 8'h10);
      repeat (3) @(posedge core_clk);
      chk({8'h00, wake_irq_q}, 9'h001);
      wr(ADDR_IRQ_EN, 8'h20);
      $display("master transmit test done");
      wr(ADDR_TX_CTRL, 8'h90);
      offer(9'h0C3);
      wr(ADDR_RX_CTRL, 8'hA0);
      poll();
      chk({1'b0, v}, 9'h020);
      repeat (2) @(posedge core_clk);
      chk({8'h00, wake_irq_q}, 9'h001);
      rdc(ADDR_RX_CTRL, 8'h80);
      rdc(ADDR_RX_BUF, 8'hC3);
      rdc(ADDR_IRQ_FLAGS, 8'h00);
      repeat (40) @(posedge core_clk);
      chk({8'h00, link.ck_line}, 9'h000);
      $display("master receive test done");
      wr(ADDR_TX_CTRL, 8'h50);
      wr(ADDR_RX_CTRL, 8'hF0);
      clk_gen <= 1'b1;
      nine_bit <= 1'b1;
      sleep_req <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         offer(k ? 9'h05A : 9'h1A5);
         poll();
         rdc(ADDR_RX_CTRL, k ? 8'hF0 : 8'hF1);
         rdc(ADDR_RX_BUF, k ? 8'h5A : 8'hA5);
      end
      $display("slave receive test done");
      wr(ADDR_RX_CTRL, 8'h80);
      wr(ADDR_TX_CTRL, 8'h30);
      wr(ADDR_IRQ_EN, 8'h10);
      nine_bit <= 1'b0;
      wr(ADDR_TX_BUF, 8'h96);
      wr(ADDR_TX_BUF, 8'h69);
      rdc(ADDR_IRQ_FLAGS, 8'h00);
      chk({8'h00, wake_irq_q}, 9'h000);
      rx_req <= 1'b1;
      rxw(9'h096);
      repeat (2) @(posedge core_clk);
      rx_req <= 1'b0;
      rxw(9'h069);
      repeat (8) @(posedge core_clk);
      rdc(ADDR_IRQ_FLAGS, 8'h10);
      rdc(ADDR_TX_CTRL, 8'h32);
      chk({8'h00, wake_irq_q}, 9'h001);
      $display("slave transmit test done");
      final_report();
   end
endmodule
